// [sac_station_ctrl.sv]
// Rules taken from the document
// R1: switches 1..99 give fixed station address
// R2: switches sampled only once after power-up
// R3: switches 00 accept class 2 address
// R4: switches 00, nothing stored: address 126
// R5: remote address stored non-volatile, reused
// R6: nonzero switches erase stored address
// R7: remote address accepted only up to 126
// R8: calibration lamp lit 0.3 s at power-up
// R9: mains absent: calibration lamp blinks 1 Hz
// R10: changed configuration: alarm lamp during boot
// R11: exchange lamp on during cyclic traffic
// R12: ready, needs calibration, fault lamp patterns
// R13: calibration run: lamp, active flag, 0 V
// R14: calibration done: flag off, rest level
// R15: failed calibration: alarm flag, 1 Hz blink
// R16: heat request gives regulation_active, heat lamp
// R17: master sends zeros before power-up
// R18: master picks communication module first
// R19: error_clear drops latched error after mains
// R20: blocked calibration request: lamp blinks 4 Hz
// R21: nonzero switches reject remote address requests
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sac_station_ctrl
    import sac_pkg::*;
#(
    parameter int BOOT_CYC  = sac_pkg::BOOT_CYC,
    parameter int CAL_CYC   = sac_pkg::CAL_CYC,
    parameter int SLOW_HALF = sac_pkg::SLOW_HALF,
    parameter int FAST_HALF = sac_pkg::FAST_HALF,
    parameter int PULSE_PER = sac_pkg::PULSE_PER,
    parameter int PULSE_W   = sac_pkg::PULSE_W
) (
    // clock and reset
    input  wire logic                       CLK,
    input  wire logic                       RST,
    // apb slave
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [7:0]                 PADDR,
    input  wire logic [31:0]                PWDATA,
    output logic      [31:0]                PRDATA,
    output logic                            PREADY,
    output logic                            PSLVERR,
    // pins: rotary switches and mains sense
    input  wire logic [sac_pkg::SW_W-1:0]   SW_TENS,
    input  wire logic [sac_pkg::SW_W-1:0]   SW_ONES,
    input  wire logic                       MAINS_OK,
    // non-volatile address store
    input  wire logic [sac_pkg::ADDR_W-1:0] NV_ADDR_IN,
    output logic                            NV_WE,
    output logic      [sac_pkg::ADDR_W-1:0] NV_WDATA,
    // fieldbus side
    input  wire logic                       SSA_REQ,
    input  wire logic [sac_pkg::ADDR_W-1:0] SSA_ADDR,
    input  wire logic                       CYCLIC_ACTIVE,
    input  wire logic                       AUTO_ZERO_REQUEST,
    input  wire logic                       HEAT_CYCLE_REQUEST,
    input  wire logic                       ERROR_CLEAR,
    // status towards fieldbus
    output logic      [sac_pkg::ADDR_W-1:0] STATION_ADDR,
    output logic                            AUTO_ZERO_ACTIVE,
    output logic                            ALARM_ACTIVE,
    output logic                            REGULATION_ACTIVE,
    output logic      [sac_pkg::LVL_W-1:0]  ACTUAL_MV,
    // indicator lamps
    output logic                            LED_CAL,
    output logic                            LED_ALARM,
    output logic                            LED_OUTPUT,
    output logic                            LED_HEAT,
    output logic                            LED_EXCH
);
    import sac_pkg::*;

    function automatic logic [6:0] bcd_to_addr(input logic [7:0] sw);
        logic [6:0] t;
        t = {3'h0, sw[7:4]};
        return 7'((t << 3) + (t << 1) + {3'h0, sw[3:0]});
    endfunction : bcd_to_addr

    // pin synchronisers
    logic [7:0] sw_s1_r, sw_s2_r;
    logic       mains_s1_r, mains_s2_r;
    always_ff @(posedge CLK)
    begin
        sw_s1_r    <= {SW_TENS, SW_ONES};
        sw_s2_r    <= sw_s1_r;
        mains_s1_r <= MAINS_OK;
        mains_s2_r <= mains_s1_r;
    end

    logic       slow, fast, pulse;
    sac_timebase #(
        .SLOW_HALF (SLOW_HALF),
        .FAST_HALF (FAST_HALF),
        .PULSE_PER (PULSE_PER),
        .PULSE_W   (PULSE_W)
    ) u_tb (
        .clk   (CLK),
        .rst   (RST),
        .slow  (slow),
        .fast  (fast),
        .pulse (pulse)
    );

    logic [4:0] ctrl_r, ctrl_nxt;

    // station address selection
    logic [1:0] cap_cnt_r, cap_cnt_nxt;
    logic       booted_r, booted_nxt, sw_zero_r, sw_zero_nxt;
    logic [6:0] sw_val_r, sw_val_nxt, addr_r, addr_nxt, nv_wdata_r, nv_wdata_nxt;
    logic       nv_we_r, nv_we_nxt, capture, ssa_ok;
    assign capture = !booted_r && (cap_cnt_r == SYNC_WAIT);
    assign ssa_ok  = booted_r && sw_zero_r && SSA_REQ && (SSA_ADDR <= ADDR_MAX);
    always_comb
    begin
        cap_cnt_nxt  = booted_r ? cap_cnt_r : 2'(cap_cnt_r + 2'h1);
        booted_nxt   = booted_r | capture;
        sw_zero_nxt  = sw_zero_r;
        sw_val_nxt   = sw_val_r;
        addr_nxt     = addr_r;
        nv_we_nxt    = 1'b0;
        nv_wdata_nxt = nv_wdata_r;
        if (capture)                                    // see R2
        begin
            sw_val_nxt  = bcd_to_addr(sw_s2_r);
            sw_zero_nxt = (sw_s2_r == 8'h00);
            if (sw_s2_r != 8'h00)
            begin
                addr_nxt     = bcd_to_addr(sw_s2_r);    // see R1
                nv_we_nxt    = 1'b1;                    // see R6
                nv_wdata_nxt = ADDR_DEFAULT;
            end
            else if (NV_ADDR_IN > ADDR_MAX)
                addr_nxt = ADDR_DEFAULT;                // see R4
            else
                addr_nxt = NV_ADDR_IN;                  // see R5
        end
        else if (ssa_ok)                                // see R3, R7, R21
        begin
            addr_nxt     = SSA_ADDR;
            nv_we_nxt    = 1'b1;                        // see R5
            nv_wdata_nxt = SSA_ADDR;
        end
    end
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cap_cnt_r  <= 2'h0;
            booted_r   <= 1'b0;
            sw_zero_r  <= 1'b0;
            sw_val_r   <= 7'h00;
            addr_r     <= ADDR_DEFAULT;
            nv_we_r    <= 1'b0;
            nv_wdata_r <= ADDR_DEFAULT;
        end
        else
        begin
            cap_cnt_r  <= cap_cnt_nxt;
            booted_r   <= booted_nxt;
            sw_zero_r  <= sw_zero_nxt;
            sw_val_r   <= sw_val_nxt;
            addr_r     <= addr_nxt;
            nv_we_r    <= nv_we_nxt;
            nv_wdata_r <= nv_wdata_nxt;
        end
    end

    // calibration, error latch and regulation
    sac_cal_t    cal_st_r, cal_st_nxt;
    logic [31:0] cal_cnt_r, cal_cnt_nxt;
    logic        calok_r, calok_nxt, calfail_r, calfail_nxt, blocked_r, blocked_nxt;
    logic        merr_r, merr_nxt, azr_d_r, reg_r, reg_nxt, alarm;
    logic [11:0] lvl_r, lvl_nxt;
    assign alarm = calfail_r | merr_r | ctrl_r[CB_FAULT];
    always_comb
    begin
        cal_st_nxt  = cal_st_r;
        cal_cnt_nxt = cal_cnt_r;
        calok_nxt   = calok_r;
        calfail_nxt = calfail_r;
        blocked_nxt = blocked_r & AUTO_ZERO_REQUEST;
        lvl_nxt     = lvl_r;
        // missing mains latches; set wins over error_clear
        merr_nxt = merr_r;
        if (ERROR_CLEAR && mains_s2_r)
            merr_nxt = 1'b0;                            // see R19
        if (!mains_s2_r)
            merr_nxt = 1'b1;
        unique case (cal_st_r)
            CAL_IDLE:
                if (AUTO_ZERO_REQUEST && !azr_d_r)
                begin
                    if (ctrl_r[CB_PERMIT] && mains_s2_r && !merr_r && !reg_r)
                    begin
                        cal_st_nxt  = CAL_RUN;          // see R13
                        cal_cnt_nxt = 32'(CAL_CYC - 1);
                        lvl_nxt     = LVL_ZERO;
                        calok_nxt   = 1'b0;
                    end
                    else
                        blocked_nxt = 1'b1;             // see R20
                end
            CAL_RUN:
                if (cal_cnt_r == 32'h0)
                begin
                    cal_st_nxt = CAL_IDLE;              // see R14
                    if (ctrl_r[CB_CALFAIL])
                        calfail_nxt = 1'b1;             // see R15
                    else
                    begin
                        calfail_nxt = 1'b0;
                        calok_nxt   = 1'b1;
                        lvl_nxt     = ctrl_r[CB_RANGE500] ? LVL_500C : LVL_300C;
                    end
                end
                else
                    cal_cnt_nxt = cal_cnt_r - 32'h1;
            default:
                cal_st_nxt = CAL_IDLE;                  // unused codes recover
        endcase
        reg_nxt = HEAT_CYCLE_REQUEST && calok_r && !alarm
                  && (cal_st_r == CAL_IDLE);            // see R16
    end
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cal_st_r  <= CAL_IDLE;
            cal_cnt_r <= 32'h0;
            calok_r   <= 1'b0;
            calfail_r <= 1'b0;
            blocked_r <= 1'b0;
            merr_r    <= 1'b0;
            azr_d_r   <= 1'b0;
            reg_r     <= 1'b0;
            lvl_r     <= LVL_ZERO;
        end
        else
        begin
            cal_st_r  <= cal_st_nxt;
            cal_cnt_r <= cal_cnt_nxt;
            calok_r   <= calok_nxt;
            calfail_r <= calfail_nxt;
            blocked_r <= blocked_nxt;
            merr_r    <= merr_nxt;
            azr_d_r   <= AUTO_ZERO_REQUEST;
            reg_r     <= reg_nxt;
            lvl_r     <= lvl_nxt;
        end
    end

    // lamp patterns
    logic [31:0] boot_cnt_r, boot_cnt_nxt;
    logic        l_cal_r, l_cal_nxt, l_alm_r, l_alm_nxt, l_out_r, l_out_nxt;
    logic        l_heat_r, l_exch_r, booting;
    assign booting = (boot_cnt_r != 32'h0);
    always_comb
    begin
        boot_cnt_nxt = booting ? boot_cnt_r - 32'h1 : 32'h0;
        if (booting)
            l_cal_nxt = 1'b1;                           // see R8
        else if (!mains_s2_r)
            l_cal_nxt = slow;                           // see R9
        else if (cal_st_r == CAL_RUN)
            l_cal_nxt = 1'b1;                           // see R13
        else if (blocked_r)
            l_cal_nxt = fast;                           // see R20
        else if (merr_r)
            l_cal_nxt = slow;
        else
            l_cal_nxt = 1'b0;
        if (booting)
            l_alm_nxt = ctrl_r[CB_CFGCHG];              // see R10
        else if (calfail_r)
            l_alm_nxt = slow;                           // see R15
        else if (merr_r || ctrl_r[CB_FAULT])
            l_alm_nxt = 1'b1;                           // see R12
        else if (!calok_r && cal_st_r == CAL_IDLE)
            l_alm_nxt = fast;                           // see R12
        else
            l_alm_nxt = 1'b0;
        if (reg_r)
            l_out_nxt = 1'b1;
        else if (!booting && calok_r && !alarm)
            l_out_nxt = pulse;                          // see R12
        else
            l_out_nxt = 1'b0;
    end
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            boot_cnt_r <= 32'(BOOT_CYC);
            l_cal_r    <= 1'b0;
            l_alm_r    <= 1'b0;
            l_out_r    <= 1'b0;
            l_heat_r   <= 1'b0;
            l_exch_r   <= 1'b0;
        end
        else
        begin
            boot_cnt_r <= boot_cnt_nxt;
            l_cal_r    <= l_cal_nxt;
            l_alm_r    <= l_alm_nxt;
            l_out_r    <= l_out_nxt;
            l_heat_r   <= reg_r;                        // see R16
            l_exch_r   <= CYCLIC_ACTIVE;                // see R11
        end
    end

    // apb slave, one wait state
    logic [31:0] prdata_r, prdata_nxt, status;
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt, acc, hit;
    assign acc    = PSEL && PENABLE;
    assign hit    = (PADDR == OFS_CTRL) || (PADDR == OFS_STATUS) || (PADDR == OFS_SWITCH);
    assign status = {17'h0, blocked_r, merr_r, calok_r, reg_r, alarm,
                     (cal_st_r == CAL_RUN), sw_zero_r, 1'b0, addr_r};
    always_comb
    begin
        pready_nxt  = acc && !pready_r;
        pslverr_nxt = acc && !pready_r && !hit;
        prdata_nxt  = 32'h0;
        ctrl_nxt    = ctrl_r;
        if (acc && !pready_r && !PWRITE)
        begin
            if (PADDR == OFS_CTRL)
                prdata_nxt = {27'h0, ctrl_r};
            else if (PADDR == OFS_STATUS)
                prdata_nxt = status;
            else if (PADDR == OFS_SWITCH)
                prdata_nxt = {25'h0, sw_val_r};
        end
        if (acc && pready_r && PWRITE && PADDR == OFS_CTRL)
            ctrl_nxt = PWDATA[4:0];
    end
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ctrl_r    <= CTRL_RESET;
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            ctrl_r    <= ctrl_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign PRDATA            = prdata_r;
    assign PREADY            = pready_r;
    assign PSLVERR           = pslverr_r;
    assign NV_WE             = nv_we_r;
    assign NV_WDATA          = nv_wdata_r;
    assign STATION_ADDR      = addr_r;
    assign AUTO_ZERO_ACTIVE  = (cal_st_r == CAL_RUN);
    assign ALARM_ACTIVE      = calfail_r;
    assign REGULATION_ACTIVE = reg_r;
    assign ACTUAL_MV         = lvl_r;
    assign LED_CAL           = l_cal_r;
    assign LED_ALARM         = l_alm_r;
    assign LED_OUTPUT        = l_out_r;
    assign LED_HEAT          = l_heat_r;
    assign LED_EXCH          = l_exch_r;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_switch_addr: assert property (capture && sw_s2_r != 8'h00 |=> // see R1
        STATION_ADDR == $past(bcd_to_addr(sw_s2_r))) else $error("switch address lost");
    a_addr_frozen: assert property (booted_r && !ssa_ok |=> $stable(STATION_ADDR)) // see R2
        else $error("address moved without request");
    a_ssa_take: assert property (ssa_ok |=> STATION_ADDR == $past(SSA_ADDR) // see R3
        && NV_WE && NV_WDATA == $past(SSA_ADDR)) else $error("remote address not taken");
    a_default_addr: assert property (capture && sw_s2_r == 8'h00 && NV_ADDR_IN > ADDR_MAX // see R4
        |=> STATION_ADDR == ADDR_DEFAULT) else $error("default address missing");
    a_erase_store: assert property (capture && sw_s2_r != 8'h00 // see R6
        |=> NV_WE && NV_WDATA == ADDR_DEFAULT) else $error("stored address not erased");
    a_reject_ssa: assert property (booted_r && SSA_REQ && (!sw_zero_r || SSA_ADDR > ADDR_MAX) // see R7
        |=> !NV_WE ##0 $stable(STATION_ADDR)) else $error("remote address wrongly taken");
    a_boot_lamp: assert property (booting && !capture |=> LED_CAL) // see R8
        else $error("boot lamp off");
    a_cal_run: assert property (AUTO_ZERO_ACTIVE |-> ACTUAL_MV == LVL_ZERO ##1 // see R13
        (LED_CAL || !AUTO_ZERO_ACTIVE)) else $error("calibration outputs wrong");
    a_cal_done: assert property (cal_st_r == CAL_RUN && cal_cnt_r == 32'h0 && !ctrl_r[CB_CALFAIL] // see R14
        |=> !AUTO_ZERO_ACTIVE && calok_r ##1 !LED_CAL || !mains_s2_r || merr_r)
        else $error("calibration end wrong");
    a_cal_fail: assert property (cal_st_r == CAL_RUN && cal_cnt_r == 32'h0 && ctrl_r[CB_CALFAIL] // see R15
        |=> ALARM_ACTIVE) else $error("failed calibration not flagged");
    a_heat_on: assert property (HEAT_CYCLE_REQUEST && calok_r && !alarm && !AUTO_ZERO_ACTIVE // see R16
        |=> REGULATION_ACTIVE ##1 LED_HEAT) else $error("regulation not started");
    a_err_clear: assert property (merr_r && ERROR_CLEAR && mains_s2_r |=> !merr_r) // see R19
        else $error("error not cleared");
    a_exch_lamp: assert property (CYCLIC_ACTIVE |=> LED_EXCH) // see R11
        else $error("exchange lamp off");
    c_cal_ok:   cover property (cal_st_r == CAL_RUN ##1 cal_st_r == CAL_IDLE && calok_r);
    c_ssa:      cover property (ssa_ok);
    c_blocked:  cover property (blocked_r && LED_CAL);
    c_heat:     cover property (REGULATION_ACTIVE);
endmodule : sac_station_ctrl
`default_nettype wire

// [sac_pkg.sv]
package sac_pkg;
    // widths
    localparam int          ADDR_W       = 7;
    localparam int          SW_W         = 4;
    localparam int          LVL_W        = 12;
    // station addresses
    localparam logic [6:0]  ADDR_DEFAULT = 7'h7e;   // 126
    localparam logic [6:0]  ADDR_MAX     = 7'h7e;   // highest remote address
    // apb register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_SWITCH   = 8'h08;
    // control register fields
    localparam int          CTRL_W       = 5;
    localparam int          CB_PERMIT    = 0;
    localparam int          CB_CFGCHG    = 1;
    localparam int          CB_RANGE500  = 2;
    localparam int          CB_CALFAIL   = 3;
    localparam int          CB_FAULT     = 4;
    localparam logic [4:0]  CTRL_RESET   = 5'h01;
    // status register fields (above the 7-bit address)
    localparam int          SB_SWZERO    = 8;
    localparam int          SB_AZACT     = 9;
    localparam int          SB_ALARM     = 10;
    localparam int          SB_REGACT    = 11;
    localparam int          SB_CALOK     = 12;
    localparam int          SB_MAINSERR  = 13;
    localparam int          SB_BLOCKED   = 14;
    // actual-value output levels in millivolts
    localparam logic [11:0] LVL_ZERO     = 12'h000;
    localparam logic [11:0] LVL_300C     = 12'h294; // 660 mV
    localparam logic [11:0] LVL_500C     = 12'h190; // 400 mV
    // timing
    localparam int          CLK_HZ       = 10_000_000;
    localparam int          BOOT_MS      = 300;
    localparam int          CAL_MS       = 10_000;
    localparam int          SLOW_HZ      = 1;
    localparam int          FAST_HZ      = 4;
    localparam int          PULSE_MS     = 1_200;
    localparam int          PULSE_W_MS   = 50;
    localparam int          BOOT_CYC     = BOOT_MS * (CLK_HZ / 1000);
    localparam int          CAL_CYC      = CAL_MS * (CLK_HZ / 1000);
    localparam int          SLOW_HALF    = CLK_HZ / (2 * SLOW_HZ);
    localparam int          FAST_HALF    = CLK_HZ / (2 * FAST_HZ);
    localparam int          PULSE_PER    = PULSE_MS * (CLK_HZ / 1000);
    localparam int          PULSE_W      = PULSE_W_MS * (CLK_HZ / 1000);
    localparam logic [1:0]  SYNC_WAIT    = 2'h3;
    // calibration sequencer
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01
    } sac_cal_t;
endpackage : sac_pkg

// [sac_timebase.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_timebase #(
    parameter int SLOW_HALF = 5_000_000,
    parameter int FAST_HALF = 1_250_000,
    parameter int PULSE_PER = 12_000_000,
    parameter int PULSE_W   = 500_000
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // blink patterns
    output logic      slow,
    output logic      fast,
    output logic      pulse
);
    logic [31:0] slow_cnt_r, slow_cnt_nxt;
    logic [31:0] fast_cnt_r, fast_cnt_nxt;
    logic [31:0] pul_cnt_r,  pul_cnt_nxt;
    logic        slow_r, slow_nxt, fast_r, fast_nxt, pulse_r, pulse_nxt;

    // free-running dividers
    always_comb
    begin
        slow_cnt_nxt = slow_cnt_r + 32'h1;
        slow_nxt     = slow_r;
        fast_cnt_nxt = fast_cnt_r + 32'h1;
        fast_nxt     = fast_r;
        pul_cnt_nxt  = pul_cnt_r + 32'h1;
        if (slow_cnt_r == 32'(SLOW_HALF - 1))
        begin
            slow_cnt_nxt = 32'h0;
            slow_nxt     = ~slow_r;
        end
        if (fast_cnt_r == 32'(FAST_HALF - 1))
        begin
            fast_cnt_nxt = 32'h0;
            fast_nxt     = ~fast_r;
        end
        if (pul_cnt_r == 32'(PULSE_PER - 1))
            pul_cnt_nxt = 32'h0;
        pulse_nxt = (pul_cnt_nxt < 32'(PULSE_W));
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            slow_cnt_r <= 32'h0;
            fast_cnt_r <= 32'h0;
            pul_cnt_r  <= 32'h0;
            slow_r     <= 1'b0;
            fast_r     <= 1'b0;
            pulse_r    <= 1'b0;
        end
        else
        begin
            slow_cnt_r <= slow_cnt_nxt;
            fast_cnt_r <= fast_cnt_nxt;
            pul_cnt_r  <= pul_cnt_nxt;
            slow_r     <= slow_nxt;
            fast_r     <= fast_nxt;
            pulse_r    <= pulse_nxt;
        end
    end

    assign slow  = slow_r;
    assign fast  = fast_r;
    assign pulse = pulse_r;
endmodule : sac_timebase
`default_nettype wire

// [sac_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_master_model
    import sac_pkg::*;
(
    // clock
    input  wire logic                     clk,
    // fieldbus controls: cyclic, autozero, heat, clear
    output logic                          ssa_req,
    output logic      [sac_pkg::ADDR_W-1:0] ssa_addr,
    output logic      [3:0]               ctl
);
    // all controls zero before power-up
    initial
    begin
        ssa_req  = 1'b0;
        ssa_addr = 7'h00;
        ctl      = 4'h0;
    end
    // one set-address request, address line scrambled once released
    task automatic ssa(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        ssa_req  <= 1'b1;
        ssa_addr <= a;
        @(posedge clk);
        ssa_req  <= 1'b0;
        ssa_addr <= ~a;
    endtask : ssa
    // all four control bits driven together at the next clock edge
    task automatic set_ctl(input logic [3:0] v);
        @(posedge clk);
        ctl <= v;
    endtask : set_ctl
endmodule : sac_master_model
`default_nettype wire

// [station_address_and_startup_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module station_address_and_startup_control_bench;
    import sac_pkg::*;
    logic        clk = 1'b0;
    logic        rst, psel, penable, pwrite, pready, pslverr, err, b;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  sw_t, sw_o, ctl;
    logic        mains, nv_we, ssa_req, azact, alarm, regact;
    logic        lcal, lalm, lout, lheat, lexch;
    logic [6:0]  nv_in, addr, ssa_addr, wdata;
    logic [11:0] mv;
    int          num_errors = 0, checks_done = 0, cyc = 0, hits;
    // clock
    always #50 clk = ~clk;
    sac_master_model pm (.clk(clk), .ssa_req(ssa_req), .ssa_addr(ssa_addr), .ctl(ctl));
    sac_station_ctrl #(.BOOT_CYC(20), .CAL_CYC(30), .FAST_HALF(2), .PULSE_PER(24),
        .PULSE_W(3)) dut (
        .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SW_TENS(sw_t), .SW_ONES(sw_o), .MAINS_OK(mains),
        .NV_ADDR_IN(nv_in), .NV_WE(nv_we), .NV_WDATA(wdata), .SSA_REQ(ssa_req),
        .SSA_ADDR(ssa_addr), .CYCLIC_ACTIVE(ctl[3]), .AUTO_ZERO_REQUEST(ctl[2]),
        .HEAT_CYCLE_REQUEST(ctl[1]), .ERROR_CLEAR(ctl[0]), .STATION_ADDR(addr),
        .AUTO_ZERO_ACTIVE(azact), .ALARM_ACTIVE(alarm), .REGULATION_ACTIVE(regact),
        .ACTUAL_MV(mv), .LED_CAL(lcal), .LED_ALARM(lalm), .LED_OUTPUT(lout),
        .LED_HEAT(lheat), .LED_EXCH(lexch));
    // non-volatile store model and hang guard
    always @(posedge clk)
    begin
        if (cyc == 0)
            nv_in <= 7'h7f;                 // store starts empty
        else if (nv_we === 1'b1)
            nv_in <= wdata;
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            num_errors = num_errors + 1;
            print_verdict();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done = checks_done + 1;
        if (s !== e)
        begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // apb transfer, held until pready sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // power cycle with a given switch setting
    task automatic do_reset(input logic [3:0] t, input logic [3:0] o);
        pm.set_ctl(4'h0);
        rst <= 1'b1;
        sw_t <= t;
        sw_o <= o;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wt(8);
    endtask : do_reset
    task automatic print_verdict();
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    // main sequence
    initial
    begin
        rst <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        mains <= 1'b1;
        do_reset(4'h0, 4'h0);
        chk("boot_lamp", lcal, 32'h1);
        chk("addr_default", addr, 32'h7e);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("swzero", rd[SB_SWZERO], 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl_reset", rd, 32'h1);
        apb(1'b1, 8'h0c, 32'h1f);
        chk("unmapped", err, 32'h1);
        pm.ssa(7'h7f);
        wt(3);
        chk("ssa_high", addr, 32'h7e);
        pm.ssa(7'h05);
        wt(3);
        chk("ssa_addr", addr, 32'h05);
        chk("nv_store", nv_in, 32'h05);
        b = lalm;
        wt(2);
        chk("alarm_fast", {lalm, lout}, {~b, 1'b0});
        pm.set_ctl(4'h8);
        wt(2);
        chk("exch_lamp", lexch, 32'h1);
        pm.set_ctl(4'hc);
        wt(3);
        chk("cal_active", {azact, lcal, mv}, 32'h3000);
        wt(35);
        chk("cal_done", {azact, lcal, mv}, {20'h0, LVL_300C});
        chk("ready_alarm", lalm, 32'h0);
        hits = 0;
        repeat (24)
        begin
            wt(1);
            hits = hits + int'(lout);
        end
        chk("out_pulse", hits, 32'h3);
        pm.set_ctl(4'ha);
        wt(3);
        chk("regulate", {regact, lheat, lout}, 32'h7);
        pm.set_ctl(4'h8);
        apb(1'b1, OFS_CTRL, 32'h09);
        pm.set_ctl(4'hc);
        wt(36);
        chk("cal_fail", alarm, 32'h1);
        mains <= 1'b0;
        wt(6);
        pm.set_ctl(4'h8);
        pm.set_ctl(4'hc);
        wt(2);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("mains_err", rd[SB_MAINSERR], 32'h1);
        chk("blocked", rd[SB_BLOCKED], 32'h1);
        mains <= 1'b1;
        wt(4);
        pm.set_ctl(4'h9);
        wt(3);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("mains_clr", rd[SB_MAINSERR], 32'h0);
        do_reset(4'h0, 4'h0);
        chk("addr_kept", addr, 32'h05);
        do_reset(4'h4, 4'h2);
        chk("addr_switch", addr, 32'h2a);
        chk("nv_erase", nv_in, 32'h7e);
        sw_o <= 4'h7;
        pm.ssa(7'h09);
        wt(4);
        chk("addr_fixed", addr, 32'h2a);
        do_reset(4'h0, 4'h0);
        chk("addr_restored", addr, 32'h7e);
        apb(1'b1, OFS_CTRL, 32'h03);
        wt(2);
        chk("cfg_lamp", lalm, 32'h1);
        print_verdict();
    end
endmodule : station_address_and_startup_control_bench
`default_nettype wire
